// File: common/scel_pkg.sv
// Package with register map, field layouts and shared types of the serial control logic
package scel_pkg;

	// Register byte offsets on the Avalon-MM slave
	localparam logic [4:0] ADDR_CTRL     = 5'h00;
	localparam logic [4:0] ADDR_FLAGS    = 5'h04;
	localparam logic [4:0] ADDR_TXHOLD   = 5'h08;
	localparam logic [4:0] ADDR_IRQSTAT  = 5'h0c;
	localparam logic [4:0] ADDR_IRQMASK  = 5'h10;

	// Widths and reset values
	localparam int         DATA_W        = 32;
	localparam int         CTRL_W        = 8;
	localparam int         IRQ_W         = 4;
	localparam int         FLAGS_W       = 6;
	localparam logic [7:0] CTRL_RESET    = 8'h00;
	localparam logic [3:0] IRQ_RESET     = 4'h0;

	// Clock-select field codes
	localparam logic [1:0] CKSEL_INT     = 2'h0;
	localparam logic [1:0] CKSEL_INT_OUT = 2'h1;
	localparam logic [1:0] CKSEL_EXT     = 2'h2;
	localparam logic [1:0] CKSEL_RSVD    = 2'h3;

	// Interrupt event bit positions in status and mask
	localparam int         IRQ_TXEMPTY   = 0;
	localparam int         IRQ_RXFULL    = 1;
	localparam int         IRQ_RXERR     = 2;
	localparam int         IRQ_TXDONE    = 3;

	// Pin synchroniser lanes
	localparam int         PIN_W         = 2;
	localparam int         PIN_RXD       = 0;
	localparam int         PIN_SCLK      = 1;

	// Decoded transfer clock source
	typedef enum logic [2:0] {
		SRC_INT_BAUD,
		SRC_INT_BAUD_OUT,
		SRC_EXT_X16,
		SRC_SYNC_INT_OUT,
		SRC_SYNC_EXT_IN,
		SRC_RESERVED
	} scel_clksrc_t;

	// Serial control register layout, bit 7 down to bit 0
	typedef struct packed {
		logic       txIrqOn;
		logic       rxIrqOn;
		logic       txOn;
		logic       rxOn;
		logic       addrFilterOn;
		logic       txDoneIrqOn;
		logic [1:0] clkSrc;
	} scel_ctrl_t;

	// Flags arriving from the status, receive and transmit logic
	typedef struct packed {
		logic txFinished;
		logic rxBufFull;
		logic framingFault;
		logic parityFault;
		logic overrunFault;
	} scel_flags_t;

	// Received frame report from the receive shifter
	typedef struct packed {
		logic done;
		logic mpBit;
	} scel_frame_t;

endpackage

// File: verilog/scel_pin_sync.sv
// Two-stage synchroniser and edge finder for asynchronous pin inputs
`timescale 1ns/1ps

module scel_pin_sync #(
	parameter int WIDTH = 2
) (
	input  wire logic             clk,
	input  wire logic             reset_n,
	input  wire logic [WIDTH-1:0] pinIn,
	output logic      [WIDTH-1:0] level,
	output logic      [WIDTH-1:0] rise,
	output logic      [WIDTH-1:0] fall
);

	genvar i;
	generate
		for (i = 0; i < WIDTH; i++) begin : gLane
			logic meta_reg, meta_next;
			logic sync_reg, sync_next;
			logic prev_reg, prev_next;

			// Next values: first stage feeds only the second
			always_comb begin
				meta_next = pinIn[i];
				sync_next = meta_reg;
				prev_next = sync_reg;
			end

			// Register the three stages
			always_ff @(posedge clk or negedge reset_n) begin
				if (!reset_n) begin
					meta_reg <= 1'b1;
					sync_reg <= 1'b1;
					prev_reg <= 1'b1;
				end else begin
					meta_reg <= meta_next;
					sync_reg <= sync_next;
					prev_reg <= prev_next;
				end
			end

			// Edges from the synchronised stages only
			assign level[i] = sync_reg;
			assign rise[i]  = sync_reg & ~prev_reg;
			assign fall[i]  = ~sync_reg & prev_reg;
		end
	endgenerate

endmodule

// File: verilog/scel_top.sv
// Serial control register, enables, interrupt requests and clock-source decode
`timescale 1ns/1ps

module scel_top (
	input  wire logic                         clk,
	input  wire logic                         reset_n,
	// Avalon-MM slave
	input  wire logic [4:0]                   address,
	input  wire logic                         read,
	input  wire logic                         write,
	input  wire logic [31:0]                  writedata,
	output logic      [31:0]                  readdata,
	output logic                              waitrequest,
	// Chip power state and frame format from the mode register
	input  wire logic                         lowPowerMode,
	input  wire logic                         syncMode,
	input  wire logic                         addrMode,
	// Flags and events from the neighbouring serial logic
	input  wire scel_pkg::scel_flags_t        flagsIn,
	input  wire logic                         txLoad,
	input  wire scel_pkg::scel_frame_t        frameIn,
	input  wire logic                         bitRateClk,
	// Serial pins
	input  wire logic                         rxdPin,
	input  wire logic                         serialClkIn,
	output logic                              serialClkOut,
	output logic                              serialClkOe,
	// Outputs towards the serial logic
	output logic                              txEnable,
	output logic                              rxEnable,
	output logic                              txBufEmpty,
	output logic                              txStart,
	output logic      [7:0]                   txData,
	output logic                              rxStart,
	output logic                              rxFlagUpdate,
	output scel_pkg::scel_clksrc_t            clkSource,
	// Interrupt requests
	output logic                              txEmptyIrq,
	output logic                              rxFullIrq,
	output logic                              rxErrIrq,
	output logic                              txDoneIrq,
	output logic                              irq
);

	scel_pkg::scel_ctrl_t   ctrl_reg, ctrl_next;
	logic                   ack_reg, ack_next;
	logic [31:0]            rdata_reg, rdata_next;
	logic                   txEmpty_reg, txEmpty_next;
	logic                   txStart_reg, txStart_next;
	logic [7:0]             txData_reg, txData_next;
	logic                   rxStart_reg, rxStart_next;
	logic                   rxUpd_reg, rxUpd_next;
	logic [3:0]             req_reg, req_next;
	logic [3:0]             istat_reg, istat_next;
	logic [3:0]             imask_reg, imask_next;
	logic                   irq_reg, irq_next;
	logic                   sclkOut_reg, sclkOut_next;
	logic                   sclkOe_reg, sclkOe_next;
	scel_pkg::scel_clksrc_t src_reg, src_next;
	logic [1:0]             pinRise, pinFall;
	logic                   wrStrobe, rdStrobe, filterActive;
	logic                   rxErrAny;
	logic [5:0]             flagView;

	// Pin inputs pass two flip-flops before any use
	scel_pin_sync #(
		.WIDTH(scel_pkg::PIN_W)
	) uPinSync (
		.clk    (clk),
		.reset_n(reset_n),
		.pinIn  ({serialClkIn, rxdPin}),
		.level  (),
		.rise   (pinRise),
		.fall   (pinFall)
	);

	// Bus handshake: one wait state; a write lands on the edge that completes it
	assign waitrequest = (read | write) & ~ack_reg;
	assign wrStrobe    = write & ack_reg;
	assign rdStrobe    = read & ~ack_reg & ~write;
	assign filterActive = ctrl_reg.addrFilterOn & addrMode & ~syncMode;
	assign rxErrAny    = flagsIn.framingFault | flagsIn.parityFault | flagsIn.overrunFault;
	assign flagView    = {flagsIn.overrunFault, flagsIn.parityFault, flagsIn.framingFault,
		flagsIn.rxBufFull, flagsIn.txFinished, txEmpty_reg};

	// Control register, holding data and transmit-empty flag
	always_comb begin
		ctrl_next    = ctrl_reg;
		txEmpty_next = txEmpty_reg;
		txStart_next = 1'b0;
		txData_next  = txData_reg;
		if (wrStrobe && address == scel_pkg::ADDR_CTRL) begin
			ctrl_next = writedata[scel_pkg::CTRL_W-1:0];
		end
		// Address frame clears the filter even against a write
		if (frameIn.done && filterActive && frameIn.mpBit) begin
			ctrl_next.addrFilterOn = 1'b0;
		end
		if (txLoad) begin
			txEmpty_next = 1'b1;
		end
		if (wrStrobe && address == scel_pkg::ADDR_TXHOLD && ctrl_reg.txOn) begin
			txData_next  = writedata[7:0];
			txEmpty_next = 1'b0;
			txStart_next = 1'b1;
		end
		if (!ctrl_reg.txOn) begin
			txEmpty_next = 1'b1;
		end
		if (lowPowerMode) begin
			ctrl_next = scel_pkg::CTRL_RESET;
		end
	end

	// Register control state
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			ctrl_reg    <= scel_pkg::CTRL_RESET;
			txEmpty_reg <= 1'b1;
			txStart_reg <= 1'b0;
			txData_reg  <= 8'h00;
		end else begin
			ctrl_reg    <= ctrl_next;
			txEmpty_reg <= txEmpty_next;
			txStart_reg <= txStart_next;
			txData_reg  <= txData_next;
		end
	end

	// Receive start detection and address filtering of finished frames
	always_comb begin
		rxStart_next = 1'b0;
		rxUpd_next   = 1'b0;
		if (ctrl_reg.rxOn) begin
			if (syncMode) begin
				rxStart_next = pinRise[scel_pkg::PIN_SCLK];
			end else begin
				rxStart_next = pinFall[scel_pkg::PIN_RXD];
			end
		end
		// Flags update only for frames the filter lets through
		if (frameIn.done) begin
			rxUpd_next = ~filterActive | frameIn.mpBit;
		end
	end

	// Register receive pulses
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			rxStart_reg <= 1'b0;
			rxUpd_reg   <= 1'b0;
		end else begin
			rxStart_reg <= rxStart_next;
			rxUpd_reg   <= rxUpd_next;
		end
	end

	// Clock-source decode and clock pin drive
	always_comb begin
		src_next     = scel_pkg::SRC_RESERVED;
		sclkOe_next  = 1'b0;
		sclkOut_next = 1'b0;
		if (!syncMode) begin
			case (ctrl_reg.clkSrc)
				scel_pkg::CKSEL_INT: begin
					src_next = scel_pkg::SRC_INT_BAUD;
				end
				scel_pkg::CKSEL_INT_OUT: begin
					src_next     = scel_pkg::SRC_INT_BAUD_OUT;
					sclkOe_next  = 1'b1;
					sclkOut_next = bitRateClk;
				end
				scel_pkg::CKSEL_EXT: begin
					src_next = scel_pkg::SRC_EXT_X16;
				end
				default: begin
					src_next = scel_pkg::SRC_RESERVED;
				end
			endcase
		end else begin
			case (ctrl_reg.clkSrc)
				scel_pkg::CKSEL_INT: begin
					src_next     = scel_pkg::SRC_SYNC_INT_OUT;
					sclkOe_next  = 1'b1;
					sclkOut_next = bitRateClk;
				end
				scel_pkg::CKSEL_EXT: begin
					src_next = scel_pkg::SRC_SYNC_EXT_IN;
				end
				default: begin
					src_next = scel_pkg::SRC_RESERVED;
				end
			endcase
		end
	end

	// Register clock pin drive and decode
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			src_reg     <= scel_pkg::SRC_INT_BAUD;
			sclkOe_reg  <= 1'b0;
			sclkOut_reg <= 1'b0;
		end else begin
			src_reg     <= src_next;
			sclkOe_reg  <= sclkOe_next;
			sclkOut_reg <= sclkOut_next;
		end
	end

	// Interrupt request levels, sticky events, mask and read clear
	always_comb begin
		req_next[scel_pkg::IRQ_TXEMPTY] = ctrl_reg.txIrqOn & txEmpty_reg;
		req_next[scel_pkg::IRQ_RXFULL]  = ctrl_reg.rxIrqOn & flagsIn.rxBufFull;
		req_next[scel_pkg::IRQ_RXERR]   = ctrl_reg.rxIrqOn & rxErrAny;
		req_next[scel_pkg::IRQ_TXDONE]  = ctrl_reg.txDoneIrqOn
			& (txEmpty_reg | flagsIn.txFinished);
		istat_next = istat_reg;
		imask_next = imask_reg;
		if (rdStrobe && address == scel_pkg::ADDR_IRQSTAT) begin
			istat_next = scel_pkg::IRQ_RESET;
		end
		if (wrStrobe && address == scel_pkg::ADDR_IRQMASK) begin
			imask_next = writedata[scel_pkg::IRQ_W-1:0];
		end
		// Rising requests set sticky bits; a set beats the read clear
		istat_next = istat_next | (req_next & ~req_reg);
		irq_next   = |(istat_next & imask_next);
	end

	// Register interrupt state
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			req_reg   <= scel_pkg::IRQ_RESET;
			istat_reg <= scel_pkg::IRQ_RESET;
			imask_reg <= scel_pkg::IRQ_RESET;
			irq_reg   <= 1'b0;
		end else begin
			req_reg   <= req_next;
			istat_reg <= istat_next;
			imask_reg <= imask_next;
			irq_reg   <= irq_next;
		end
	end

	// Bus answer and read data; unmapped reads return zero
	always_comb begin
		ack_next   = (read | write) & ~ack_reg;
		rdata_next = rdata_reg;
		if (rdStrobe) begin
			case (address)
				scel_pkg::ADDR_CTRL: begin
					rdata_next = {24'h000000, ctrl_reg};
				end
				scel_pkg::ADDR_FLAGS: begin
					rdata_next = {26'h0, flagView};
				end
				scel_pkg::ADDR_TXHOLD: begin
					rdata_next = {24'h000000, txData_reg};
				end
				scel_pkg::ADDR_IRQSTAT: begin
					rdata_next = {28'h0000000, istat_reg};
				end
				scel_pkg::ADDR_IRQMASK: begin
					rdata_next = {28'h0000000, imask_reg};
				end
				default: begin
					rdata_next = 32'h00000000;
				end
			endcase
		end
	end

	// Register bus answer
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			ack_reg   <= 1'b0;
			rdata_reg <= 32'h00000000;
		end else begin
			ack_reg   <= ack_next;
			rdata_reg <= rdata_next;
		end
	end

	// Outputs; receive flags pass untouched when reception is disabled
	assign readdata     = rdata_reg;
	assign txEnable     = ctrl_reg.txOn;
	assign rxEnable     = ctrl_reg.rxOn;
	assign txBufEmpty   = txEmpty_reg;
	assign txStart      = txStart_reg;
	assign txData       = txData_reg;
	assign rxStart      = rxStart_reg;
	assign rxFlagUpdate = rxUpd_reg;
	assign clkSource    = src_reg;
	assign serialClkOut = sclkOut_reg;
	assign serialClkOe  = sclkOe_reg;
	assign txEmptyIrq   = req_reg[scel_pkg::IRQ_TXEMPTY];
	assign rxFullIrq    = req_reg[scel_pkg::IRQ_RXFULL];
	assign rxErrIrq     = req_reg[scel_pkg::IRQ_RXERR];
	assign txDoneIrq    = req_reg[scel_pkg::IRQ_TXDONE];
	assign irq          = irq_reg;

endmodule

// File: tb/scel_assertions.sv
// Checker with the concurrent assertions of the serial control logic
`timescale 1ns/1ps

module scel_assertions (
	input  wire logic                  clk,
	input  wire logic                  reset_n,
	input  wire logic [4:0]            address,
	input  wire logic                  write,
	input  wire logic                  lowPowerMode,
	input  wire scel_pkg::scel_flags_t flagsIn,
	input  wire scel_pkg::scel_frame_t frameIn,
	input  wire logic                  txEnable,
	input  wire logic                  rxEnable,
	input  wire logic                  txBufEmpty,
	input  wire logic                  txStart,
	input  wire logic                  rxStart,
	input  wire logic                  rxFlagUpdate,
	input  wire logic                  rxFullIrq,
	input  wire logic                  rxErrIrq,
	input  wire logic                  txDoneIrq
);
	// All checks run on the system clock and rest during reset
	default clocking cb @(posedge clk); endclocking
	default disable iff (!reset_n);

	a_power_clear: assert property (lowPowerMode |=> !txEnable && !rxEnable)
		else $error("control not cleared in low power");
	a_tx_off_empty: assert property (!txEnable && !$past(txEnable) |-> txBufEmpty)
		else $error("empty flag low while transmit off");
	a_tx_start_cause: assert property (txStart |-> !txBufEmpty && txEnable && $past(write)
		&& $past(address) == scel_pkg::ADDR_TXHOLD) else $error("bad transmit start");
	a_full_source: assert property (rxFullIrq |-> $past(flagsIn.rxBufFull))
		else $error("full request without flag");
	a_err_source: assert property (rxErrIrq |-> $past(flagsIn.framingFault)
		|| $past(flagsIn.parityFault) || $past(flagsIn.overrunFault))
		else $error("error request without flag");
	a_rx_start_gate: assert property (rxStart |-> $past(rxEnable))
		else $error("reception started while off");
	a_frame_accept: assert property (rxFlagUpdate |-> $past(frameIn.done))
		else $error("flag update without frame");
	a_done_source: assert property (txDoneIrq |-> $past(txBufEmpty)
		|| $past(flagsIn.txFinished)) else $error("done request without flag");
endmodule

bind scel_top scel_assertions u_assertions (.*);

// File: tb/scel_remote.sv
// Remote serial sender driving the receive data and clock pins
`timescale 1ns/1ps

module scel_remote (
	input  wire logic frameGo,
	input  wire logic syncFrame,
	output logic      rxd,
	output logic      sclk
);
	// Idle line is high and the clock stands still outside frames
	initial begin
		rxd = 1'b1;
		sclk = 1'b1;
	end

	// One frame per request: start bit low, then alternating bits
	always @(posedge frameGo) begin
		for (int i = 0; i < 10; i++) begin
			rxd = (i == 0) ? 1'b0 : i[0];
			sclk = !syncFrame;
			#40;
			sclk = 1'b1;
			#40;
		end
		rxd = 1'b1;
	end
endmodule

// File: tb/testbench.sv
// Self-checking bench for the serial control logic
`timescale 1ns/1ps

module testbench;
	logic        clk = 1'b0, reset_n = 1'b0, read = 1'b0, write = 1'b0;
	logic        lowPowerMode = 1'b0, syncMode = 1'b0, addrMode = 1'b0;
	logic        txLoad = 1'b0, bitRateClk = 1'b0, frameGo = 1'b0;
	logic [4:0]  address = 5'h00, flagsIn = 5'h00;
	logic [1:0]  frameIn = 2'h0;
	logic [31:0] writedata = 32'h0, readdata;
	logic [2:0]  clkSource;
	logic [7:0]  txData;
	logic        waitrequest, rxdPin, serialClkIn, serialClkOut, serialClkOe, irq;
	logic        txEnable, rxEnable, txBufEmpty, txStart, rxStart, rxFlagUpdate;
	logic        txEmptyIrq, rxFullIrq, rxErrIrq, txDoneIrq;
	int          numErrors = 0, nCompared = 0, nStarts = 0;

	scel_top u_dut (
		.clk         (clk),
		.reset_n     (reset_n),
		.address     (address),
		.read        (read),
		.write       (write),
		.writedata   (writedata),
		.readdata    (readdata),
		.waitrequest (waitrequest),
		.lowPowerMode(lowPowerMode),
		.syncMode    (syncMode),
		.addrMode    (addrMode),
		.flagsIn     (flagsIn),
		.txLoad      (txLoad),
		.frameIn     (frameIn),
		.bitRateClk  (bitRateClk),
		.rxdPin      (rxdPin),
		.serialClkIn (serialClkIn),
		.serialClkOut(serialClkOut),
		.serialClkOe (serialClkOe),
		.txEnable    (txEnable),
		.rxEnable    (rxEnable),
		.txBufEmpty  (txBufEmpty),
		.txStart     (txStart),
		.txData      (txData),
		.rxStart     (rxStart),
		.rxFlagUpdate(rxFlagUpdate),
		.clkSource   (clkSource),
		.txEmptyIrq  (txEmptyIrq),
		.rxFullIrq   (rxFullIrq),
		.rxErrIrq    (rxErrIrq),
		.txDoneIrq   (txDoneIrq),
		.irq         (irq)
	);
	scel_remote u_remote (.frameGo(frameGo), .syncFrame(syncMode), .rxd(rxdPin),
		.sclk(serialClkIn));

	// Clocks and a count of accepted holding writes
	always #5 clk = ~clk;
	always @(posedge clk) bitRateClk <= ~bitRateClk;
	always @(negedge clk) if (txStart === 1'b1) nStarts++;

	// Verdict and end of run
	task automatic results();
		$display("compared %0d mismatches %0d", nCompared, numErrors);
		if (numErrors == 0 && nCompared > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		nCompared++;
		if (got !== exp) begin
			numErrors++;
			$display("mismatch at %0t got %h expected %h", $time, got, exp);
		end
	endtask
	// Bus transfer held until waitrequest is low at an edge
	task automatic xfer(input logic isWr, input logic [4:0] a, input logic [31:0] d,
		output logic [31:0] q);
		int n;
		n = 0;
		@(posedge clk);
		address <= a;
		write <= isWr;
		read <= !isWr;
		writedata <= d;
		@(posedge clk);
		while (waitrequest !== 1'b0 && n < 50) begin
			@(posedge clk);
			n++;
		end
		q = readdata;
		read <= 1'b0;
		write <= 1'b0;
		if (n == 50) begin
			numErrors++;
			results();
		end
	endtask
	task automatic wr(input logic [4:0] a, input logic [31:0] d);
		logic [31:0] q;
		xfer(1'b1, a, d, q);
	endtask
	task automatic rd(input logic [4:0] a, input logic [31:0] exp);
		logic [31:0] q;
		xfer(1'b0, a, 32'h0, q);
		check(q, exp);
	endtask
	task automatic step(input int n);
		repeat (n) @(posedge clk);
		@(negedge clk);
	endtask

	// Clock-select codes in both modes
	task automatic t_clk();
		logic [23:0] srcExp = {3'h5, 3'h4, 3'h5, 3'h3, 3'h5, 3'h2, 3'h1, 3'h0};
		logic [7:0] oeExp = 8'h12;
		for (int i = 0; i < 8; i++) begin
			@(posedge clk);
			syncMode <= i[2];
			wr(scel_pkg::ADDR_CTRL, 32'(i[1:0]));
			step(1);
			check(clkSource, srcExp[3*i+:3]);
			check(serialClkOe, oeExp[i]);
			check(serialClkOut, oeExp[i] & ~bitRateClk);
		end
		$display("test clock select done");
	endtask
	// Transmit enable, empty flag and its request
	task automatic t_tx();
		@(posedge clk);
		syncMode <= 1'b0;
		wr(scel_pkg::ADDR_TXHOLD, 32'h5a);
		wr(scel_pkg::ADDR_CTRL, 32'ha0);
		step(1);
		check({txEnable, txBufEmpty, txEmptyIrq}, 3'h7);
		wr(scel_pkg::ADDR_TXHOLD, 32'h3c);
		step(1);
		check({txBufEmpty, txEmptyIrq, txData}, 10'h03c);
		check(nStarts, 1);
		@(posedge clk);
		txLoad <= 1'b1;
		@(posedge clk);
		txLoad <= 1'b0;
		step(1);
		check({txBufEmpty, txEmptyIrq}, 2'h3);
		wr(scel_pkg::ADDR_TXHOLD, 32'h11);
		wr(scel_pkg::ADDR_CTRL, 32'h00);
		step(1);
		check(txBufEmpty, 1'b1);
		$display("test transmit done");
	endtask
	// Receive requests, start detection and held flags
	task automatic t_rx();
		int n;
		@(posedge clk);
		flagsIn <= 5'h08;
		wr(scel_pkg::ADDR_CTRL, 32'h50);
		step(1);
		check({rxEnable, rxFullIrq, rxErrIrq}, 3'h6);
		@(posedge clk);
		flagsIn <= 5'h07;
		step(1);
		check({rxFullIrq, rxErrIrq}, 2'h1);
		@(posedge clk);
		flagsIn <= 5'h08;
		wr(scel_pkg::ADDR_CTRL, 32'h10);
		step(1);
		check({rxFullIrq, rxErrIrq}, 2'h0);
		for (int m = 0; m < 2; m++) begin
			@(posedge clk);
			syncMode <= m[0];
			frameGo <= 1'b1;
			n = 0;
			while (rxStart !== 1'b1 && n < 20) begin
				@(negedge clk);
				n++;
			end
			check(n < 20, 1'b1);
			if (n == 20) begin
				results();
			end
			repeat (90) @(posedge clk);
			frameGo <= 1'b0;
		end
		wr(scel_pkg::ADDR_CTRL, 32'h00);
		rd(scel_pkg::ADDR_FLAGS, 32'h05);
		$display("test receive done");
	endtask
	// Address filter drops and address frames
	task automatic t_filter();
		logic [2:0] mp = 3'h2, upd = 3'h6;
		@(posedge clk);
		syncMode <= 1'b0;
		addrMode <= 1'b1;
		wr(scel_pkg::ADDR_CTRL, 32'h18);
		for (int i = 0; i < 3; i++) begin
			@(posedge clk);
			frameIn <= {1'b1, mp[i]};
			@(posedge clk);
			frameIn <= 2'h0;
			@(negedge clk);
			check(rxFlagUpdate, upd[i]);
		end
		rd(scel_pkg::ADDR_CTRL, 32'h10);
		$display("test filter done");
	endtask
	// Done request, sticky status, mask and low power
	task automatic t_irq();
		logic [31:0] q;
		@(posedge clk);
		flagsIn <= 5'h00;
		xfer(1'b0, scel_pkg::ADDR_IRQSTAT, 32'h0, q);
		wr(scel_pkg::ADDR_CTRL, 32'h04);
		step(2);
		check({txDoneIrq, irq}, 2'h2);
		wr(scel_pkg::ADDR_IRQMASK, 32'h8);
		step(1);
		check(irq, 1'b1);
		rd(scel_pkg::ADDR_IRQMASK, 32'h8);
		rd(scel_pkg::ADDR_IRQSTAT, 32'h8);
		rd(scel_pkg::ADDR_IRQSTAT, 32'h0);
		step(1);
		check(irq, 1'b0);
		wr(scel_pkg::ADDR_CTRL, 32'hf0);
		@(posedge clk);
		lowPowerMode <= 1'b1;
		@(posedge clk);
		lowPowerMode <= 1'b0;
		step(1);
		check(txDoneIrq, 1'b0);
		rd(scel_pkg::ADDR_CTRL, 32'h0);
		$display("test interrupts done");
	endtask

	// Main sequence
	initial begin
		repeat (20) @(posedge clk);
		reset_n <= 1'b1;
		rd(scel_pkg::ADDR_CTRL, 32'h0);
		rd(scel_pkg::ADDR_FLAGS, 32'h1);
		rd(5'h14, 32'h0);
		$display("test reset done");
		t_clk();
		t_tx();
		t_rx();
		t_filter();
		t_irq();
		results();
	end
endmodule
